// ### hw/tvs_pkg.sv
// Contract
// R01: Alternate table needs segment, fuse, enable bit
// R02: Alternate table serves every interrupt and trap
// R03: Alternate table at last boot page start
// R04: Enable refused below two boot pages
// R05: Both tables inherit boot segment protection
// R06: Reset loads program counter with zero
// R07: Eight trap vectors, fixed trap priorities
// R08: Math causes share one trap vector
// R09: Request n maps to vector n plus 8
// R10: Priority fields four per word; reserved none
// R11: Table entry holds 24-bit handler address
// R12: Equal priority: lower vector served first
// R13: Seven user priority levels
// R14: Forward only flagged, enabled, above core priority
package tvs_pkg;
  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [5:0] ADR_CTL1 = 6'h00;
  localparam logic [5:0] ADR_CTL2 = 6'h01;
  localparam logic [5:0] ADR_CTL3 = 6'h02;
  localparam logic [5:0] ADR_CTL4 = 6'h03;
  localparam logic [5:0] ADR_BOOT_LIMIT = 6'h04;
  localparam logic [5:0] ADR_EVT = 6'h05;
  localparam logic [5:0] ADR_MASK = 6'h06;
  localparam logic [5:0] ADR_FLAG0 = 6'h08;
  localparam logic [5:0] ADR_EN0 = 6'h0C;
  localparam logic [5:0] ADR_PRIO0 = 6'h10;
  localparam int FLAG_WORDS = 3;
  localparam int PRIO_WORDS = 11;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int C1_OSC = 1;
  localparam int C1_STACK = 2;
  localparam int C1_ADDR = 3;
  localparam int C1_MATH = 4;
  localparam int C1_EN_OVA = 10;
  localparam int C1_EN_OVB = 9;
  localparam int C1_EN_MISC = 8;
  localparam int C2_ALT_EN = 8;
  localparam int C2_SWT_EN = 13;
  localparam int C4_SWT = 0;
  localparam int C4_ECC = 1;
  localparam int BOOT_LIMIT_W = 13;
  localparam int EVT_TRAP = 0;
  localparam int EVT_IRQ = 1;
  localparam int EVT_REFUSED = 2;
  // Math type flag positions: ova, ovb, cova, covb, shift, div0
  localparam logic [15:0] C1_TYPE_MASK = 16'h7800 | 16'h00C0;
  localparam logic [15:0] C1_RW_MASK = 16'hFFDE;
  localparam logic [15:0] C2_RW_MASK = 16'h2100;
  localparam logic [15:0] C3_MASK = 16'h8311;
  localparam logic [15:0] C4_MASK = 16'h0003;
  localparam logic [15:0] PRIO_MASK = 16'h7777;
  // ----------------------------------------------------------------
  // Vectors and priorities
  // ----------------------------------------------------------------
  localparam logic [23:0] RESET_PC = 24'h000000;
  localparam logic [23:0] TABLE_OFS = 24'h000004;
  localparam logic [7:0] IRQ_VEC_BASE = 8'h08;
  localparam logic [3:0] PRI_OSC = 4'hF;
  localparam logic [3:0] PRI_ADDR = 4'hE;
  localparam logic [3:0] PRI_HARD = 4'hD;
  localparam logic [3:0] PRI_STACK = 4'hC;
  localparam logic [3:0] PRI_MATH = 4'hB;
  localparam logic [3:0] PRI_SOFT = 4'h9;
  localparam logic [12:0] MIN_BOOT_PAGES = 13'h0002;
  // Reserved request numbers 5, 22, 32-34, 39, 42
  localparam logic [47:0] IRQ_RSV = 48'h0487_0040_0020;

  function automatic logic [23:0] vec_addr(input logic [23:0] base, input logic [7:0] num);
    vec_addr = base + TABLE_OFS + {15'h0000, num, 1'b0};
  endfunction
endpackage

// ### hw/tvs_trap_sel.sv
`timescale 1ns/1ps
module tvs_trap_sel import tvs_pkg::*; (
  input wire logic [5:0] pend_in,
  output logic hit_out,
  output logic [7:0] num_out,
  output logic [3:0] prio_out
);
  // Pending order: osc, addr, hard, stack, math, soft
  assign hit_out = |pend_in;
  always_comb begin
    num_out = 8'h06;
    prio_out = PRI_SOFT;
    if (pend_in[0]) begin  // [R07]
      num_out = 8'h00;
      prio_out = PRI_OSC;
    end else if (pend_in[1]) begin
      num_out = 8'h01;
      prio_out = PRI_ADDR;
    end else if (pend_in[2]) begin
      num_out = 8'h02;
      prio_out = PRI_HARD;
    end else if (pend_in[3]) begin
      num_out = 8'h03;
      prio_out = PRI_STACK;
    end else if (pend_in[4]) begin  // [R08]
      num_out = 8'h04;
      prio_out = PRI_MATH;
    end
  end
endmodule

// ### hw/tvs_irq_sel.sv
`timescale 1ns/1ps
module tvs_irq_sel import tvs_pkg::*; #(
  parameter int NUM_IRQ = 43
) (
  input wire logic [NUM_IRQ-1:0] pend_in,
  input wire logic [4*NUM_IRQ-1:0] prio_in,
  input wire logic [3:0] cpu_prio_in,
  output logic hit_out,
  output logic [7:0] num_out,
  output logic [2:0] prio_out
);
  logic [2:0] p;
  always_comb begin
    hit_out = 1'b0;
    num_out = 8'h00;
    prio_out = 3'h0;
    p = 3'h0;
    // Ascending scan with strict compare keeps the lowest number on ties
    for (int n = 0; n < NUM_IRQ; n++) begin
      p = prio_in[4*n +: 3];
      if (pend_in[n] && p != 3'h0 && {1'b0, p} > cpu_prio_in &&  // [R14] [R13]
          (!hit_out || p > prio_out)) begin  // [R12]
        hit_out = 1'b1;
        num_out = 8'(n);
        prio_out = p;
      end
    end
  end
endmodule

// ### hw/tvs_top.sv
`timescale 1ns/1ps
module tvs_top import tvs_pkg::*; #(
  parameter int NUM_IRQ = 43,
  parameter logic [23:0] PAGE_SIZE = 24'h000800
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [5:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic boot_segment_in,
  input wire logic alt_fuse_prog_in,
  input wire logic osc_fail_in,
  input wire logic addr_err_in,
  input wire logic ecc_dbl_in,
  input wire logic sw_trap_in,
  input wire logic stack_err_in,
  input wire logic [5:0] math_in,
  input wire logic [4:0] soft_in,
  input wire logic [NUM_IRQ-1:0] irq_src_in,
  input wire logic [3:0] cpu_prio_in,
  input wire logic vec_ack_in,
  input wire logic table_valid_in,
  input wire logic [23:0] table_data_in,
  output logic vec_req_out,
  output logic [7:0] vec_num_out,
  output logic [3:0] vec_prio_out,
  output logic [23:0] vec_addr_out,
  output logic alt_active_out,
  output logic vec_protect_out,
  output logic handler_valid_out,
  output logic [23:0] handler_addr_out,
  output logic pc_load_out,
  output logic [23:0] pc_value_out,
  output logic irq_out
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] ctl1_q, ctl1_d, ctl2_q, ctl2_d, ctl3_q, ctl3_d, ctl4_q, ctl4_d;
  logic [BOOT_LIMIT_W-1:0] boot_limit_q;
  logic [2:0] evt_q, evt_d, mask_q, evt_set;
  logic [16*FLAG_WORDS-1:0] flag_q, flag_d, en_q;
  logic [16*PRIO_WORDS-1:0] prio_q;
  logic vec_req_q, alt_q, prot_q, hv_q, pcl_q;
  logic [7:0] vnum_q;
  logic [3:0] vprio_q;
  logic [23:0] vaddr_q, haddr_q;
  logic [15:0] rdata_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic [5:0] flag_ofs = addr_in - ADR_FLAG0;
  wire logic [5:0] en_ofs = addr_in - ADR_EN0;
  wire logic [5:0] prio_ofs = addr_in - ADR_PRIO0;
  wire logic wr_flag = wr_in && addr_in >= ADR_FLAG0 && flag_ofs < 6'(FLAG_WORDS);
  wire logic wr_en = wr_in && addr_in >= ADR_EN0 && en_ofs < 6'(FLAG_WORDS);
  wire logic wr_prio = wr_in && addr_in >= ADR_PRIO0 && prio_ofs < 6'(PRIO_WORDS);
  // Three priority bits for every request that exists
  function automatic logic [16*PRIO_WORDS-1:0] prio_bits(input logic [47:0] ok);
    prio_bits = '0;
    for (int n = 0; n < 4*PRIO_WORDS; n++) begin
      prio_bits[4*n +: 3] = {3{ok[n]}};
    end
  endfunction

  wire logic [47:0] irq_ok = ~IRQ_RSV & ((48'h1 << NUM_IRQ) - 48'h1);
  wire logic [16*PRIO_WORDS-1:0] prio_ok = prio_bits(irq_ok);  // [R10]
  wire logic [15:0] prio_keep = PRIO_MASK & prio_ok[16*prio_ofs[3:0] +: 16];
  wire logic pages_ok = boot_limit_q >= MIN_BOOT_PAGES;
  wire logic alt_try = wr_in && addr_in == ADR_CTL2 && wdata_in[C2_ALT_EN];

  // Both tables carry boot segment protection
  wire logic protect = boot_segment_in;  // [R05]
  wire logic alt_eff = boot_segment_in && alt_fuse_prog_in &&  // [R01]
                       ctl2_q[C2_ALT_EN] && pages_ok;  // [R04]
  // Alternate table at first address of last boot page
  wire logic [23:0] alt_base = 24'({11'h000, boot_limit_q} - 24'h1) * PAGE_SIZE;  // [R03]
  wire logic [23:0] tbl_base = alt_eff ? alt_base : 24'h000000;  // [R02]

  // ----------------------------------------------------------------
  // Trap flags
  // ----------------------------------------------------------------
  wire logic [5:0] math_en = {{4{ctl1_q[C1_EN_MISC]}}, ctl1_q[C1_EN_OVB], ctl1_q[C1_EN_OVA]};
  wire logic [5:0] math_hit = math_in & math_en;  // [R08]
  wire logic [15:0] c1_set = {1'b0, math_hit[0], math_hit[1], math_hit[2], math_hit[3],
                              3'h0, math_hit[4], math_hit[5], 1'b0, |math_hit,
                              addr_err_in, stack_err_in, osc_fail_in, 1'b0};
  wire logic [15:0] c3_set = {soft_in[4], 5'h00, soft_in[3], soft_in[2], 3'h0,
                              soft_in[1], 3'h0, soft_in[0]};
  wire logic [15:0] c4_set = {14'h0000, ecc_dbl_in, sw_trap_in};
  wire logic hard_pend = ctl4_q[C4_ECC] || (ctl4_q[C4_SWT] && ctl2_q[C2_SWT_EN]);
  wire logic [5:0] trap_pend = {|(ctl3_q & C3_MASK), ctl1_q[C1_MATH], ctl1_q[C1_STACK],
                                hard_pend, ctl1_q[C1_ADDR], ctl1_q[C1_OSC]};

  // Hardware set wins over a software write of zero
  always_comb begin
    ctl1_d = (wr_in && addr_in == ADR_CTL1) ? (wdata_in & C1_RW_MASK) : ctl1_q;
    ctl1_d = ctl1_d | (c1_set & (C1_TYPE_MASK | 16'h001E));
    ctl3_d = ((wr_in && addr_in == ADR_CTL3) ? wdata_in : ctl3_q) & C3_MASK;
    ctl3_d = ctl3_d | c3_set;
    ctl4_d = ((wr_in && addr_in == ADR_CTL4) ? wdata_in : ctl4_q) & C4_MASK;
    ctl4_d = ctl4_d | c4_set;
    ctl2_d = ctl2_q;
    if (wr_in && addr_in == ADR_CTL2) begin
      ctl2_d = wdata_in & C2_RW_MASK;
      ctl2_d[C2_ALT_EN] = wdata_in[C2_ALT_EN] && pages_ok;  // [R04]
    end
  end

  // ----------------------------------------------------------------
  // Peripheral flags, enables, priorities
  // ----------------------------------------------------------------
  always_comb begin
    flag_d = flag_q;
    if (wr_flag) begin
      flag_d[16*flag_ofs[1:0] +: 16] = wdata_in;
    end
    flag_d = (flag_d | {{(48-NUM_IRQ){1'b0}}, irq_src_in}) & irq_ok;  // [R10]
  end

  wire logic [NUM_IRQ-1:0] irq_pend = NUM_IRQ'(flag_q & en_q);  // [R14]

  // ----------------------------------------------------------------
  // Selection
  // ----------------------------------------------------------------
  logic trap_hit, irq_hit;
  logic [7:0] trap_num, irq_num;
  logic [3:0] trap_prio;
  logic [2:0] irq_prio;

  tvs_trap_sel u_trap (
    .pend_in(trap_pend),
    .hit_out(trap_hit),
    .num_out(trap_num),
    .prio_out(trap_prio)
  );

  tvs_irq_sel #(.NUM_IRQ(NUM_IRQ)) u_irq (
    .pend_in(irq_pend),
    .prio_in(prio_q[4*NUM_IRQ-1:0]),
    .cpu_prio_in(cpu_prio_in),
    .hit_out(irq_hit),
    .num_out(irq_num),
    .prio_out(irq_prio)
  );

  // Traps always outrank user levels
  wire logic [7:0] sel_num = trap_hit ? trap_num : irq_num + IRQ_VEC_BASE;  // [R09]
  wire logic [3:0] sel_prio = trap_hit ? trap_prio : {1'b0, irq_prio};  // [R07]
  wire logic sel_hit = trap_hit || irq_hit;

  assign evt_set = {alt_try && !pages_ok, vec_ack_in && vec_req_q && vnum_q >= IRQ_VEC_BASE,
                    vec_ack_in && vec_req_q && vnum_q < IRQ_VEC_BASE};
  assign evt_d = ((rd_in && addr_in == ADR_EVT) ? 3'h0 : evt_q) | evt_set;

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  logic [15:0] rmux;
  always_comb begin
    rmux = 16'h0000;
    case (addr_in)
      ADR_CTL1: rmux = ctl1_q;
      ADR_CTL2: rmux = ctl2_q;
      ADR_CTL3: rmux = ctl3_q;
      ADR_CTL4: rmux = ctl4_q;
      ADR_BOOT_LIMIT: rmux = {3'h0, boot_limit_q};
      ADR_EVT: rmux = {13'h0000, evt_q};
      ADR_MASK: rmux = {13'h0000, mask_q};
      default: begin
        if (addr_in >= ADR_FLAG0 && flag_ofs < 6'(FLAG_WORDS)) begin
          rmux = flag_q[16*flag_ofs[1:0] +: 16];
        end else if (addr_in >= ADR_EN0 && en_ofs < 6'(FLAG_WORDS)) begin
          rmux = en_q[16*en_ofs[1:0] +: 16];
        end else if (addr_in >= ADR_PRIO0 && prio_ofs < 6'(PRIO_WORDS)) begin
          rmux = prio_q[16*prio_ofs[3:0] +: 16];
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin  // [R06]
      ctl1_q <= 16'h0000;
      ctl2_q <= 16'h0000;
      ctl3_q <= 16'h0000;
      ctl4_q <= 16'h0000;
      boot_limit_q <= '0;
      evt_q <= 3'h0;
      mask_q <= 3'h0;
      flag_q <= '0;
      en_q <= '0;
      prio_q <= '0;
      rdata_q <= 16'h0000;
    end else begin
      ctl1_q <= ctl1_d;
      ctl2_q <= ctl2_d;
      ctl3_q <= ctl3_d;
      ctl4_q <= ctl4_d;
      evt_q <= evt_d;
      flag_q <= flag_d;
      rdata_q <= rd_in ? rmux : 16'h0000;
      if (wr_in && addr_in == ADR_BOOT_LIMIT) boot_limit_q <= wdata_in[BOOT_LIMIT_W-1:0];
      if (wr_in && addr_in == ADR_MASK) mask_q <= wdata_in[2:0];
      if (wr_en) en_q[16*en_ofs[1:0] +: 16] <= wdata_in & irq_ok[16*en_ofs[1:0] +: 16];
      if (wr_prio) prio_q[16*prio_ofs[3:0] +: 16] <= wdata_in & prio_keep;  // [R10]
    end
  end

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      vec_req_q <= 1'b0;
      vnum_q <= 8'h00;
      vprio_q <= 4'h0;
      vaddr_q <= 24'h000000;
      alt_q <= 1'b0;
      prot_q <= 1'b0;
      hv_q <= 1'b0;
      haddr_q <= 24'h000000;
      pcl_q <= 1'b1;
    end else begin
      vec_req_q <= sel_hit;
      vnum_q <= sel_num;
      vprio_q <= sel_prio;
      vaddr_q <= vec_addr(tbl_base, sel_num);  // [R09] [R02]
      alt_q <= alt_eff;
      prot_q <= protect;
      hv_q <= table_valid_in;
      if (table_valid_in) haddr_q <= table_data_in;  // [R11]
      pcl_q <= 1'b0;
    end
  end

  assign rdata_out = rdata_q;
  assign vec_req_out = vec_req_q;
  assign vec_num_out = vnum_q;
  assign vec_prio_out = vprio_q;
  assign vec_addr_out = vaddr_q;
  assign alt_active_out = alt_q;
  assign vec_protect_out = prot_q;
  assign handler_valid_out = hv_q;
  assign handler_addr_out = haddr_q;
  assign pc_load_out = pcl_q;
  assign pc_value_out = RESET_PC;
  assign irq_out = |(evt_q & mask_q);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_alt_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R01]
    alt_active_out |-> $past(boot_segment_in) && $past(alt_fuse_prog_in))
    else $error("alternate table active without segment or fuse");
  a_alt_pages: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R04]
    alt_active_out |-> $past(boot_limit_q) >= MIN_BOOT_PAGES)
    else $error("alternate table active below two pages");
  a_vec_addr: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R02]
    vec_req_out && alt_active_out |-> vec_addr_out == vec_addr($past(alt_base), vec_num_out))
    else $error("vector address not in alternate table");
  a_irq_map: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R09]
    vec_req_out && !alt_active_out |-> vec_addr_out == 24'h4 + {15'h0, vec_num_out, 1'b0})
    else $error("default vector address wrong");
  a_trap_first: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R07]
    trap_hit |=> vec_req_out && vec_num_out < IRQ_VEC_BASE && vec_prio_out >= PRI_SOFT)
    else $error("trap not chosen first");
  a_prio_above: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R14]
    vec_req_out && vec_num_out >= IRQ_VEC_BASE |->
      vec_prio_out > $past(cpu_prio_in) && vec_prio_out != 4'h0)
    else $error("request forwarded at or below core level");
  a_math_route: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R08]
    |math_hit |=> ctl1_q[C1_MATH] ##1 (vec_num_out == 8'h04 || $past(trap_pend[3:0]) != 4'h0))
    else $error("math cause not routed");
  a_no_reserved: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R10]
    (flag_q & IRQ_RSV) == 48'h0 && (en_q & IRQ_RSV) == 48'h0)
    else $error("reserved request holds a flag or enable");
  a_reset_pc: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R06]
    !$past(resetn_in) |-> pc_load_out && pc_value_out == 24'h0)
    else $error("program counter not zeroed after reset");
  a_pc_release: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R06]
    $past(resetn_in) |-> !pc_load_out)
    else $error("program counter load held after reset");
  a_handler_load: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R11]
    table_valid_in |=> handler_valid_out && handler_addr_out == $past(table_data_in))
    else $error("handler address not captured");
  a_protect: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R05]
    $past(resetn_in) |-> vec_protect_out == $past(boot_segment_in))
    else $error("table protection not following boot segment");
  a_refuse_evt: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R04]
    alt_try && !pages_ok |=> evt_q[EVT_REFUSED] && !ctl2_q[C2_ALT_EN])
    else $error("alternate table enable not refused");
  a_rsv_prio: assert property (@(posedge clk_in) disable iff (!resetn_in)  // [R10]
    (prio_q & ~prio_ok) == '0)
    else $error("reserved request holds a priority field");
  c_alt_vector: cover property (@(posedge clk_in) disable iff (!resetn_in)
    vec_req_out && alt_active_out);
  c_irq_vector: cover property (@(posedge clk_in) disable iff (!resetn_in)
    vec_req_out && vec_num_out >= IRQ_VEC_BASE ##1 vec_ack_in);
  c_refused: cover property (@(posedge clk_in) disable iff (!resetn_in)
    evt_q[EVT_REFUSED]);
  c_trap_vector: cover property (@(posedge clk_in) disable iff (!resetn_in)
    vec_req_out && vec_num_out < IRQ_VEC_BASE ##1 vec_ack_in);
endmodule

// ### tb/tvs_core_model.sv
`timescale 1ns/1ps
module tvs_core_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [1:0] lat_in,
  input wire logic vec_req_in,
  input wire logic [23:0] vec_addr_in,
  output logic table_valid_out,
  output logic [23:0] table_data_out,
  output logic vec_ack_out
);
  // ------------------------------
  // Core fetch of table entries
  // ------------------------------
  logic busy_q = 1'b0;
  logic [1:0] cnt_q = 2'h0;
  logic valid_q = 1'b0;
  logic [23:0] data_q = 24'h5A5A5A;
  logic [23:0] addr_q = 24'h000000;
  assign table_valid_out = valid_q;
  assign vec_ack_out = valid_q;
  assign table_data_out = data_q;
  always @(posedge clk_in) begin
    valid_q <= 1'b0;
    // Data line toggles outside a fetch
    data_q <= ~data_q;
    // A new vector while one is held restarts the fetch
    if (!resetn_in || !vec_req_in || (busy_q && vec_addr_in != addr_q)) begin
      busy_q <= 1'b0;
      cnt_q <= 2'h0;
    end else if (!busy_q && cnt_q == lat_in) begin
      valid_q <= 1'b1;
      data_q <= vec_addr_in ^ 24'hA5A5A5;
      addr_q <= vec_addr_in;
      busy_q <= 1'b1;
    end else if (!busy_q) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import tvs_pkg::*;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [5:0] addr_in = 6'h00;
  logic [15:0] wdata_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic boot_in = 1'b0;
  logic fuse_in = 1'b0;
  logic [4:0] trap_in = 5'h00;
  logic [5:0] math_in = 6'h00;
  logic [4:0] soft_in = 5'h00;
  logic [42:0] irq_in = '0;
  logic [3:0] cpu_in = 4'h0;
  logic [1:0] lat = 2'h0;
  logic ack, tvld, req, alt, prot, hvld, pcl, irq_out;
  logic [15:0] rdata_out;
  logic [23:0] tdat, vaddr, haddr, pcv;
  logic [7:0] vnum;
  logic [3:0] vpri;
  int fail_count = 0;
  int n_compared = 0;
  always #10 clk_in = ~clk_in;

  tvs_top dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .boot_segment_in(boot_in), .alt_fuse_prog_in(fuse_in), .osc_fail_in(trap_in[0]),
    .addr_err_in(trap_in[1]), .ecc_dbl_in(trap_in[2]), .sw_trap_in(trap_in[3]),
    .stack_err_in(trap_in[4]), .math_in(math_in), .soft_in(soft_in), .irq_src_in(irq_in),
    .cpu_prio_in(cpu_in), .vec_ack_in(ack), .table_valid_in(tvld), .table_data_in(tdat),
    .vec_req_out(req), .vec_num_out(vnum), .vec_prio_out(vpri), .vec_addr_out(vaddr),
    .alt_active_out(alt), .vec_protect_out(prot), .handler_valid_out(hvld),
    .handler_addr_out(haddr), .pc_load_out(pcl), .pc_value_out(pcv), .irq_out(irq_out));
  tvs_core_model core_u (.clk_in(clk_in), .resetn_in(resetn_in), .lat_in(lat),
    .vec_req_in(req), .vec_addr_in(vaddr), .table_valid_out(tvld),
    .table_data_out(tdat), .vec_ack_out(ack));

  // ------------------------------
  // Shared tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wait_hi(ref logic s, input string nm);
    int i;
    for (i = 0; i < 8 && s !== 1'b1; i++) cyc(1);
    if (i == 8) begin
      fail_count++;
      $display("[ERR] %s expected 1 seen timeout", nm);
      give_verdict();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask
  task automatic pulse(input logic [42:0] m);
    @(posedge clk_in);
    irq_in <= m;
    @(posedge clk_in);
    irq_in <= '0;
  endtask
  task automatic setup(input int n, input int p);
    wr(ADR_EN0 + 6'(n / 16), 16'h0001 << (n % 16));
    wr(ADR_PRIO0 + 6'(n / 4), 16'(p) << (4 * (n % 4)));
  endtask
  task automatic clear_req();
    for (int i = 0; i < 3; i++) begin
      wr(ADR_FLAG0 + 6'(i), 16'h0000);
      wr(ADR_EN0 + 6'(i), 16'h0000);
    end
  endtask
  task automatic chk_vec(input int num, input int p, input logic [23:0] base);
    wait_hi(req, "vec_req");
    chk("vec_num", 24'(vnum), 24'(num));
    chk("vec_prio", 24'(vpri), 24'(p));
    chk("vec_addr", vaddr, base + 24'h000004 + 24'(2 * num));
  endtask
  task automatic chk_idle(input int n);
    cyc(n);
    chk("vec_req", 24'(req), 24'h000000);
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  task automatic t_regs();
    logic [15:0] v;
    wr(6'h3F, 16'hFFFF);
    rd(6'h3F, v);
    chk("unmapped", 24'(v), 24'h000000);
    wr(ADR_EN0, 16'hFFFF);
    rd(ADR_EN0, v);
    chk("enable_0", 24'(v), 24'h00FFDF);
    wr(ADR_PRIO0, 16'hFFFF);
    rd(ADR_PRIO0, v);
    chk("prio_0", 24'(v), 24'h007777);
    wr(ADR_EN0 + 6'h02, 16'hFFFF);
    rd(ADR_EN0 + 6'h02, v);
    chk("enable_2", 24'(v), 24'h000378);
    wr(ADR_PRIO0 + 6'h01, 16'h0030);
    rd(ADR_PRIO0 + 6'h01, v);
    chk("prio_rsv", 24'(v), 24'h000000);
    pulse(43'h20);
    chk_idle(4);
    wr(ADR_EN0, 16'h0000);
  endtask
  task automatic t_map();
    int ns[6] = '{0, 1, 4, 15, 16, 41};
    foreach (ns[k]) begin
      lat <= 2'(k % 3);
      clear_req();
      setup(ns[k], 3);
      pulse(43'h1 << ns[k]);
      chk_vec(ns[k] + 8, 3, 24'h0);
      wait_hi(hvld, "handler_valid");
      chk("handler", haddr, (24'h14 + 24'(2 * ns[k])) ^ 24'hA5A5A5);
      wr(ADR_FLAG0 + 6'(ns[k] / 16), 16'h0000);
      chk_idle(3);
    end
  endtask
  task automatic t_prio();
    clear_req();
    setup(2, 3);
    @(posedge clk_in);
    cpu_in <= 4'h3;
    pulse(43'h4);
    chk_idle(4);
    @(posedge clk_in);
    cpu_in <= 4'h2;
    chk_vec(10, 3, 24'h0);
    wr(ADR_PRIO0, 16'h0000);
    chk_idle(2);
    wr(ADR_PRIO0, 16'h0700);
    @(posedge clk_in);
    cpu_in <= 4'h6;
    chk_vec(10, 7, 24'h0);
    wr(ADR_EN0, 16'h0000);
    chk_idle(2);
    @(posedge clk_in);
    cpu_in <= 4'h0;
  endtask
  task automatic t_order();
    clear_req();
    wr(ADR_EN0, 16'h0208);
    wr(ADR_PRIO0, 16'h4000);
    wr(ADR_PRIO0 + 6'h02, 16'h0040);
    pulse(43'h208);
    chk_vec(11, 4, 24'h0);
    wr(ADR_FLAG0, 16'h0200);
    cyc(2);
    chk_vec(17, 4, 24'h0);
  endtask
  task automatic t_traps(input logic [23:0] base, input logic [15:0] c2);
    int tn[16] = '{0, 1, 2, 2, 3, 4, 4, 4, 4, 4, 4, 6, 6, 6, 6, 6};
    int tp[16] = '{15, 14, 13, 13, 12, 11, 11, 11, 11, 11, 11, 9, 9, 9, 9, 9};
    clear_req();
    setup(1, 7);
    wr(ADR_CTL1, 16'h0700);
    wr(ADR_CTL2, c2);
    pulse(43'h2);
    chk_vec(9, 7, base);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk_in);
      if (i < 5) trap_in[i] <= 1'b1;
      else if (i < 11) math_in[i - 5] <= 1'b1;
      else soft_in[i - 11] <= 1'b1;
      @(posedge clk_in);
      trap_in <= 5'h00;
      math_in <= 6'h00;
      soft_in <= 5'h00;
      cyc(1);
      chk_vec(tn[i], tp[i], base);
      wr(ADR_CTL1, 16'h0700);
      wr(ADR_CTL3, 16'h0000);
      wr(ADR_CTL4, 16'h0000);
      cyc(2);
    end
  endtask
  task automatic t_alt();
    logic [15:0] v;
    clear_req();
    wr(ADR_MASK, 16'h0004);
    wr(ADR_BOOT_LIMIT, 16'h0001);
    boot_in <= 1'b1;
    fuse_in <= 1'b1;
    wr(ADR_CTL2, 16'h0100);
    cyc(2);
    chk("alt_active", 24'(alt), 24'h0);
    chk("irq_out", 24'(irq_out), 24'h1);
    rd(ADR_CTL2, v);
    chk("ctl2", 24'(v), 24'h0);
    rd(ADR_EVT, v);
    chk("evt_status", 24'(v[2:0]), 24'h000007);
    cyc(1);
    chk("irq_out", 24'(irq_out), 24'h0);
    wr(ADR_BOOT_LIMIT, 16'h0003);
    wr(ADR_CTL2, 16'h0100);
    cyc(2);
    chk("alt_active", 24'(alt), 24'h1);
    chk("protect", 24'(prot), 24'h1);
    fuse_in <= 1'b0;
    cyc(3);
    chk("alt_active", 24'(alt), 24'h0);
    fuse_in <= 1'b1;
    boot_in <= 1'b0;
    cyc(3);
    chk("alt_active", 24'(alt), 24'h0);
    chk("protect", 24'(prot), 24'h0);
    boot_in <= 1'b1;
    cyc(3);
    chk("alt_active", 24'(alt), 24'h1);
    t_traps(24'h001000, 16'h2100);
  endtask

  initial begin
    cyc(1);
    chk("pc_load", 24'(pcl), 24'h1);
    chk("pc_value", pcv, 24'h000000);
    @(posedge clk_in);
    resetn_in <= 1'b1;
    cyc(3);
    chk("pc_load", 24'(pcl), 24'h0);
    t_regs();
    t_map();
    t_prio();
    t_order();
    t_traps(24'h000000, 16'h2000);
    t_alt();
    give_verdict();
  end
endmodule
